// ===== logic/bcfg_top.sv
// Start-up configuration, identification and boot loader control.
// --------------------------------------------------------------------------
// --------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module bcfg_top
    import bcfg_pkg::*;
#(
    parameter logic [15:0] PART_CODE = 16'h1234, // Arbitrary value.
    parameter logic [3:0] REV_CODE = 4'h1, // Arbitrary value.
    parameter logic [10:0] CFG_CODE = 11'h000,
    parameter logic [7:0] STARTUP_RST = 8'h08,
    parameter logic [7:0] EEADDR_RST = 8'h50
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host register port
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [9:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    // Internal memory image source
    output logic otp_rd,
    output logic [7:0] otp_addr,
    input wire logic otp_valid,
    input wire logic [7:0] otp_data,
    // EEPROM master engine
    output logic eep_start,
    output logic [6:0] eeprom_bus_address,
    output logic eeprom_two_byte_offset,
    output logic [7:0] eep_offset,
    input wire logic eep_arb_lost,
    input wire logic eep_valid,
    input wire logic [7:0] eep_data,
    input wire logic eep_nack,
    input wire logic eep_crc_ok,
    // Status
    output logic loading,
    output logic boot_failure_flag
);
    import bcfg_pkg::*;

    // ----------------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------------
    bcfg_blk_t blk;
    always_comb
    begin
        if (host_addr <= BCFG_OFS_EEADDR)
            blk = BCFG_BLK_START;
        else if (host_addr <= BCFG_OFS_ID3)
            blk = BCFG_BLK_ID;
        else if (host_addr <= BCFG_OFS_SIF_HI)
            blk = BCFG_BLK_SIF;
        else if (host_addr >= BCFG_OFS_PLL_LO && host_addr <= BCFG_OFS_PLL_HI)
            blk = BCFG_BLK_PLL;
        else if (host_addr >= BCFG_OFS_IRQ_LO && host_addr <= BCFG_OFS_IRQ_HI)
            blk = BCFG_BLK_IRQ;
        else if (host_addr >= BCFG_OFS_GST_LO && host_addr <= BCFG_OFS_GST_HI)
            blk = BCFG_BLK_GST;
        else
            blk = BCFG_BLK_RSVD;
    end

    // ----------------------------------------------------------------------
    // Boot sequencer
    // ----------------------------------------------------------------------
    bcfg_state_t st_q, st_d;
    logic [7:0] idx_q, idx_d;
    logic [4:0] rty_q, rty_d;
    logic fail_q, fail_d;
    logic busy_q, busy_d;
    logic start_d;
    logic [7:0] startup_q, startup_d;
    logic [7:0] eeaddr_q, eeaddr_d;
    logic [31:0] id_q, id_d;
    logic mem_we;
    logic [9:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic host_ok;
    logic [7:0] img_data;
    logic img_we;
    logic [7:0] otp_last;

    // Host accesses drop silently while the loader owns the registers.
    assign host_ok = !busy_q;
    assign otp_last = startup_q[BCFG_PARTIAL_BIT]
        ? 8'(BCFG_PARTIAL_BYTES - 1)
        : 8'(BCFG_OTP_BYTES - 1);

    always_comb
    begin
        st_d = st_q;
        idx_d = idx_q;
        rty_d = rty_q;
        fail_d = fail_q;
        busy_d = busy_q;
        start_d = 1'b0;
        img_we = 1'b0;
        img_data = 8'h00;
        unique case (st_q)
            BCFG_ST_IDLE:
            begin
                st_d = BCFG_ST_OTP;
                idx_d = 8'h00;
                busy_d = 1'b1;
            end
            BCFG_ST_OTP:
            begin
                if (otp_valid)
                begin
                    img_we = 1'b1;
                    img_data = otp_data;
                    idx_d = idx_q + 8'h01;
                    if (idx_q == otp_last)
                    begin
                        idx_d = 8'h00;
                        if (!startup_q[BCFG_EXTDIS_BIT])
                        begin
                            st_d = BCFG_ST_ARB;
                            rty_d = startup_q[7:BCFG_RTY_LSB];
                            start_d = 1'b1;
                        end
                        else
                            st_d = BCFG_ST_DONE;
                    end
                end
            end
            BCFG_ST_ARB:
            begin
                if (eep_arb_lost)
                begin
                    if (rty_q == 5'h00)
                    begin
                        fail_d = 1'b1;
                        st_d = BCFG_ST_DONE;
                    end
                    else
                    begin
                        rty_d = rty_q - 5'h01;
                        start_d = 1'b1;
                    end
                end
                else if (eep_valid)
                    st_d = BCFG_ST_EEP;
                else if (eep_nack)
                begin
                    fail_d = 1'b1;
                    st_d = BCFG_ST_DONE;
                end
            end
            BCFG_ST_EEP:
            begin
                if (eep_nack)
                begin
                    fail_d = 1'b1;
                    st_d = BCFG_ST_DONE;
                end
                else if (eep_valid)
                begin
                    idx_d = idx_q + 8'h01;
                    if (idx_q == BCFG_CRC_OFS)
                    begin
                        fail_d = !eep_crc_ok;
                        st_d = BCFG_ST_DONE;
                    end
                    else
                    begin
                        img_we = 1'b1;
                        img_data = eep_data;
                    end
                end
            end
            BCFG_ST_DONE:
            begin
                busy_d = 1'b0;
            end
        endcase
        // The first arbitration result arrives in ARB, the first data byte
        // is taken there too as byte zero; image bytes up to index 7 are not stored.
        if (st_q == BCFG_ST_ARB && eep_valid && !eep_arb_lost)
        begin
            img_we = 1'b1;
            img_data = eep_data;
            idx_d = 8'h01;
        end
    end

    // ----------------------------------------------------------------------
    // Registers and host writes
    // ----------------------------------------------------------------------
    always_comb
    begin
        startup_d = startup_q;
        eeaddr_d = eeaddr_q;
        id_d = id_q;
        mem_we = 1'b0;
        mem_waddr = {2'b00, idx_q};
        mem_wdata = img_data;
        if (img_we && idx_q > 8'h07)
            mem_we = 1'b1;
        else if (host_wr && host_ok)
        begin
            unique case (host_addr)
                BCFG_OFS_STARTUP: startup_d = host_wdata;
                BCFG_OFS_EEADDR: eeaddr_d = host_wdata;
                BCFG_OFS_ID0: id_d[31:24] = host_wdata;
                BCFG_OFS_ID1: id_d[23:16] = host_wdata;
                BCFG_OFS_ID2: id_d[15:8] = host_wdata;
                BCFG_OFS_ID3: id_d[7:0] = host_wdata;
                default:
                begin
                    mem_we = (blk != BCFG_BLK_RSVD);
                    mem_waddr = host_addr;
                    mem_wdata = host_wdata;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q <= BCFG_ST_IDLE;
            idx_q <= 8'h00;
            rty_q <= BCFG_RTY_RST;
            fail_q <= 1'b0;
            busy_q <= 1'b1;
            startup_q <= STARTUP_RST;
            eeaddr_q <= EEADDR_RST;
            id_q <= {REV_CODE, PART_CODE, CFG_CODE, 1'b1};
        end
        else
        begin
            st_q <= st_d;
            idx_q <= idx_d;
            rty_q <= rty_d;
            fail_q <= fail_d;
            busy_q <= busy_d;
            startup_q <= startup_d;
            eeaddr_q <= eeaddr_d;
            id_q <= id_d;
        end
    end

    bcfg_mem #(.DEPTH(1024), .AW(10)) u_mem (
        .clk(clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(host_addr),
        .rdata(mem_rdata)
    );

    // ----------------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------------
    logic rd_q;
    logic [9:0] raddr_q;
    logic [7:0] rsel_q;
    logic rsvd_q;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_q <= 1'b0;
            raddr_q <= 10'h000;
            rsel_q <= 8'h00;
            rsvd_q <= 1'b0;
        end
        else
        begin
            rd_q <= host_rd && host_ok;
            raddr_q <= host_addr;
            rsvd_q <= blk == BCFG_BLK_RSVD;
            unique case (host_addr)
                BCFG_OFS_STARTUP: rsel_q <= startup_q;
                BCFG_OFS_EEADDR: rsel_q <= eeaddr_q;
                BCFG_OFS_ID0: rsel_q <= id_q[31:24];
                BCFG_OFS_ID1: rsel_q <= id_q[23:16];
                BCFG_OFS_ID2: rsel_q <= id_q[15:8];
                BCFG_OFS_ID3: rsel_q <= id_q[7:0];
                BCFG_OFS_GST_HI - 10'h001: rsel_q <= {7'h00, fail_q};
                default: rsel_q <= 8'h00;
            endcase
        end
    end

    logic use_mem;
    // Reserved space reads as zero, since the host never writes its memory bytes
    // and they would otherwise return image data or whatever powered up there.
    assign use_mem = raddr_q > BCFG_OFS_ID3
        && raddr_q != BCFG_OFS_GST_HI - 10'h001
        && !rsvd_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            host_rdata <= 8'h00;
            host_rvalid <= 1'b0;
        end
        else
        begin
            host_rdata <= use_mem ? mem_rdata : rsel_q;
            host_rvalid <= rd_q;
        end
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            otp_rd <= 1'b0;
            otp_addr <= 8'h00;
            eep_start <= 1'b0;
            eeprom_bus_address <= 7'h00;
            eeprom_two_byte_offset <= 1'b0;
            eep_offset <= 8'h00;
            loading <= 1'b1;
            boot_failure_flag <= 1'b0;
        end
        else
        begin
            otp_rd <= st_d == BCFG_ST_OTP;
            otp_addr <= idx_d;
            eep_start <= start_d;
            eeprom_bus_address <= eeaddr_q[6:0];
            eeprom_two_byte_offset <= eeaddr_q[BCFG_TWOBYTE_BIT];
            eep_offset <= 8'h00;
            loading <= busy_d;
            boot_failure_flag <= fail_d;
        end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    ignore_busy_a: assert property (@(posedge clk) disable iff (rst)
        busy_q && host_rd |=> !rd_q) else $error("read taken while loading");
    retry_reload_a: assert property (@(posedge clk) disable iff (rst)
        st_q == BCFG_ST_OTP && st_d == BCFG_ST_ARB |=> rty_q == $past(startup_q[7:3]))
        else $error("retry not reloaded");
    retry_dec_a: assert property (@(posedge clk) disable iff (rst)
        st_q == BCFG_ST_ARB && eep_arb_lost && rty_q != 5'h00 |=> rty_q == $past(rty_q) - 5'h01)
        else $error("retry not decremented");
    retry_exhaust_a: assert property (@(posedge clk) disable iff (rst)
        st_q == BCFG_ST_ARB && eep_arb_lost && rty_q == 5'h00 |=> ##1 boot_failure_flag)
        else $error("no failure after retries");
    nack_fail_a: assert property (@(posedge clk) disable iff (rst)
        st_q == BCFG_ST_EEP && eep_nack |=> boot_failure_flag)
        else $error("nack did not fail boot");
    skip_eep_a: assert property (@(posedge clk) disable iff (rst)
        st_q == BCFG_ST_OTP && startup_q[0] |=> st_q != BCFG_ST_ARB)
        else $error("eeprom used while disabled");
    partial_end_a: assert property (@(posedge clk) disable iff (rst)
        st_q == BCFG_ST_OTP && otp_valid && startup_q[1] |-> idx_q <= 8'h07)
        else $error("partial load overran");
    offset_mode_a: assert property (@(posedge clk) disable iff (rst)
        ##1 eeprom_two_byte_offset == $past(eeaddr_q[7]))
        else $error("offset mode wrong");
    id_write_a: assert property (@(posedge clk) disable iff (rst)
        host_wr && host_ok && host_addr == BCFG_OFS_ID3 |=> id_q[7:0] == $past(host_wdata))
        else $error("config code write lost");
    cov_full_c: cover property (@(posedge clk) st_q == BCFG_ST_EEP ##1 st_q == BCFG_ST_DONE);
    cov_retry_c: cover property (@(posedge clk) st_q == BCFG_ST_ARB && eep_arb_lost);
    cov_fail_c: cover property (@(posedge clk) $rose(boot_failure_flag));
endmodule : bcfg_top
`default_nettype wire

// ===== logic/bcfg_pkg.sv
// Package for the boot configuration and identification register block.
package bcfg_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [9:0] BCFG_OFS_STARTUP = 10'h000;
    localparam logic [9:0] BCFG_OFS_EEADDR = 10'h001;
    localparam logic [9:0] BCFG_OFS_ID0 = 10'h002;
    localparam logic [9:0] BCFG_OFS_ID1 = 10'h003;
    localparam logic [9:0] BCFG_OFS_ID2 = 10'h004;
    localparam logic [9:0] BCFG_OFS_ID3 = 10'h005;
    localparam logic [9:0] BCFG_OFS_SIF_LO = 10'h006;
    localparam logic [9:0] BCFG_OFS_SIF_HI = 10'h007;
    localparam logic [9:0] BCFG_OFS_PLL_LO = 10'h033;
    localparam logic [9:0] BCFG_OFS_PLL_HI = 10'h03E;
    localparam logic [9:0] BCFG_OFS_IRQ_LO = 10'h200;
    localparam logic [9:0] BCFG_OFS_IRQ_HI = 10'h203;
    localparam logic [9:0] BCFG_OFS_GST_LO = 10'h213;
    localparam logic [9:0] BCFG_OFS_GST_HI = 10'h215;
    localparam logic [9:0] BCFG_OFS_LAST = 10'h3FF;
    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int BCFG_RTY_LSB = 3;
    localparam int BCFG_PARTIAL_BIT = 1;
    localparam int BCFG_EXTDIS_BIT = 0;
    localparam int BCFG_TWOBYTE_BIT = 7;
    localparam logic [4:0] BCFG_RTY_RST = 5'h01;
    localparam int BCFG_PARTIAL_BYTES = 8;
    // Image end: the checksum sits in the last loaded byte.
    localparam logic [7:0] BCFG_CRC_OFS = 8'hB4;
    localparam int BCFG_OTP_BYTES = 181;
    // ------------------------------------------------------------------
    // Address blocks
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        BCFG_BLK_START = 7'h01,
        BCFG_BLK_ID = 7'h02,
        BCFG_BLK_SIF = 7'h04,
        BCFG_BLK_PLL = 7'h08,
        BCFG_BLK_IRQ = 7'h10,
        BCFG_BLK_GST = 7'h20,
        BCFG_BLK_RSVD = 7'h40
    } bcfg_blk_t;
    typedef enum logic [4:0] {
        BCFG_ST_IDLE = 5'h01,
        BCFG_ST_OTP = 5'h02,
        BCFG_ST_ARB = 5'h04,
        BCFG_ST_EEP = 5'h08,
        BCFG_ST_DONE = 5'h10
    } bcfg_state_t;
endpackage : bcfg_pkg

// ===== logic/bcfg_mem.sv
// Byte-wide register memory with registered read data.
`timescale 1ns/10ps
`default_nettype none
module bcfg_mem #(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem_q [DEPTH];
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem_q[waddr] <= wdata;
        end
        rdata <= mem_q[raddr];
    end
endmodule : bcfg_mem
`default_nettype wire

// ===== dv/bcfg_partner.sv
// Image source and EEPROM master engine model facing the boot loader.
`timescale 1ns/10ps
`default_nettype none
module bcfg_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Scenario control and counts
    input wire logic slow,
    input wire logic [3:0] lose_n,
    input wire logic [8:0] nack_at,
    input wire logic crc_bad,
    output logic [8:0] otp_cnt,
    output logic [3:0] start_cnt,
    // Internal image port
    input wire logic otp_rd,
    input wire logic [7:0] otp_addr,
    output logic otp_valid,
    output logic [7:0] otp_data,
    // EEPROM engine port
    input wire logic eep_start,
    output logic eep_arb_lost,
    output logic eep_valid,
    output logic [7:0] eep_data,
    output logic eep_nack,
    output logic eep_crc_ok
);
    logic [3:0] ow;
    logic [3:0] ew;
    logic [3:0] lost;
    logic [8:0] idx;
    logic run;
    // ------------------------------------------------------------------
    // Internal image
    // ------------------------------------------------------------------
    // A gap after each byte lets the loader move its index first.
    always_ff @(posedge clk)
    begin
        otp_valid <= 1'b0;
        otp_data <= ~otp_data;
        if (rst)
        begin
            ow <= 4'h1;
            otp_cnt <= 9'h000;
            otp_data <= 8'h00;
        end
        else if (otp_valid)
            ow <= slow ? 4'h3 : 4'h1;
        else if (ow != 4'h0)
            ow <= ow - 4'h1;
        else if (otp_rd)
        begin
            otp_valid <= 1'b1;
            otp_data <= otp_addr ^ 8'hA5;
            otp_cnt <= otp_cnt + 9'h001;
        end
    end
    // ------------------------------------------------------------------
    // EEPROM engine
    // ------------------------------------------------------------------
    // Data and checksum lines toggle outside a byte so stale values fail.
    always_ff @(posedge clk)
    begin
        eep_arb_lost <= 1'b0;
        eep_valid <= 1'b0;
        eep_nack <= 1'b0;
        eep_data <= ~eep_data;
        eep_crc_ok <= ~eep_crc_ok;
        if (rst)
        begin
            run <= 1'b0;
            lost <= 4'h0;
            start_cnt <= 4'h0;
            ew <= 4'h0;
            eep_data <= 8'h00;
            eep_crc_ok <= 1'b0;
        end
        else if (eep_start)
        begin
            start_cnt <= start_cnt + 4'h1;
            if (lost < lose_n)
            begin
                lost <= lost + 4'h1;
                eep_arb_lost <= 1'b1;
            end
            else
            begin
                run <= 1'b1;
                idx <= 9'h000;
                ew <= slow ? 4'h3 : 4'h1;
            end
        end
        else if (run)
        begin
            if (ew != 4'h0)
                ew <= ew - 4'h1;
            else if (idx == nack_at)
            begin
                eep_nack <= 1'b1;
                run <= 1'b0;
            end
            else
            begin
                ew <= slow ? 4'h3 : 4'h1;
                eep_valid <= 1'b1;
                eep_data <= idx[7:0] ^ 8'h3C;
                eep_crc_ok <= !crc_bad;
                idx <= idx + 9'h001;
                run <= (idx != 9'h0B4);
            end
        end
    end
endmodule : bcfg_partner
`default_nettype wire

// ===== dv/bcfg_top_tb.sv
// Self-checking bench for the boot configuration and identification block.
`timescale 1ns/10ps
`default_nettype none
module bcfg_top_tb;
    import bcfg_pkg::*;
    // Revision, part and configuration codes are arbitrary.
    localparam logic [31:0] ID = {4'h9, 16'hC3A5, 11'h5B6, 1'b1};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [9:0] host_addr = 10'h000;
    logic [7:0] host_wdata = 8'h00;
    logic slow = 1'b0;
    logic [3:0] lose_n = 4'h0;
    logic [8:0] nack_at = 9'h1FF;
    logic crc_bad = 1'b0;
    logic [31:0] seed = 32'h0000A722;
    logic [7:0] v;
    logic [7:0] w;
    logic [7:0] s;
    int cyc = 0;
    int fail_count = 0;
    int check_count = 0;
    logic [7:0] expq [$];
    int cycq [$];
    wire [1:0] host_rvalid, otp_rd, otp_valid, eep_start, two_b, arb_lost;
    wire [1:0] eep_valid, nack, crc_ok, loading, fail;
    wire [7:0] host_rdata [2];
    wire [7:0] otp_addr [2];
    wire [7:0] otp_data [2];
    wire [7:0] eep_off [2];
    wire [7:0] eep_data [2];
    wire [6:0] ee_addr [2];
    wire [8:0] pcnt [2];
    wire [3:0] scnt [2];

    always #2 clk = ~clk;
    // ------------------------------------------------------------------
    // Devices and partners
    // ------------------------------------------------------------------
    // The second device boots from eight image bytes with EEPROM disabled.
    for (genvar g = 0; g < 2; g++)
    begin : g_dut
        bcfg_top #(.PART_CODE(ID[27:12]), .REV_CODE(ID[31:28]),
            .CFG_CODE(ID[11:1]), .STARTUP_RST(g == 0 ? 8'h08 : 8'h0B)) uut (
            .clk(clk), .rst(rst), .host_wr(host_wr), .host_rd(host_rd),
            .host_addr(host_addr), .host_wdata(host_wdata),
            .host_rdata(host_rdata[g]), .host_rvalid(host_rvalid[g]),
            .otp_rd(otp_rd[g]), .otp_addr(otp_addr[g]),
            .otp_valid(otp_valid[g]), .otp_data(otp_data[g]),
            .eep_start(eep_start[g]), .eeprom_bus_address(ee_addr[g]),
            .eeprom_two_byte_offset(two_b[g]), .eep_offset(eep_off[g]),
            .eep_arb_lost(arb_lost[g]), .eep_valid(eep_valid[g]),
            .eep_data(eep_data[g]), .eep_nack(nack[g]),
            .eep_crc_ok(crc_ok[g]), .loading(loading[g]),
            .boot_failure_flag(fail[g]));
        bcfg_partner pm (.clk(clk), .rst(rst), .slow(slow),
            .lose_n(lose_n), .nack_at(nack_at), .crc_bad(crc_bad),
            .otp_cnt(pcnt[g]), .start_cnt(scnt[g]), .otp_rd(otp_rd[g]),
            .otp_addr(otp_addr[g]), .otp_valid(otp_valid[g]),
            .otp_data(otp_data[g]), .eep_start(eep_start[g]),
            .eep_arb_lost(arb_lost[g]), .eep_valid(eep_valid[g]),
            .eep_data(eep_data[g]), .eep_nack(nack[g]),
            .eep_crc_ok(crc_ok[g]));
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time,
                seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    function automatic logic [7:0] rnd8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd8

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        host_rd <= 1'b0;
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        host_wr <= 1'b0;
        host_rd <= 1'b1;
        host_addr <= a;
        expq.push_back(e);
        cycq.push_back(cyc + 1);
        @(posedge clk);
    endtask : rd

    task automatic idle();
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        @(posedge clk);
    endtask : idle

    // Host traffic during the load must leave no trace.
    task automatic boot(input logic sl, input logic [3:0] ln,
        input logic [8:0] na, input logic cb);
        int n;
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        // Let a read still in flight deliver its data before reset.
        repeat (4) @(posedge clk);
        rst <= 1'b1;
        slow <= sl;
        lose_n <= ln;
        nack_at <= na;
        crc_bad <= cb;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        wr(BCFG_OFS_ID3, 8'hAA);
        host_wr <= 1'b0;
        host_rd <= 1'b1;
        @(posedge clk);
        idle();
        n = 0;
        while (loading !== 2'b00 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000)
        begin
            fail_count++;
            results();
        end
    endtask : boot
    // ------------------------------------------------------------------
    // Read data monitor
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (host_rvalid[0] === 1'b1)
        begin
            if (expq.size() == 0)
                chk(1, 0);
            else
            begin
                chk(host_rdata[0], expq.pop_front());
                chk(cyc - cycq.pop_front(), 2);
            end
        end
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        boot(1'b0, 4'h0, 9'h1FF, 1'b0);
        chk(pcnt[0], BCFG_OTP_BYTES);
        chk(pcnt[1], BCFG_PARTIAL_BYTES);
        chk(scnt[0], 1);
        chk(scnt[1], 0);
        chk(fail, 2'b00);
        chk(ee_addr[0], 7'h50);
        chk({two_b[0], eep_off[0]}, 9'h000);
        rd(BCFG_OFS_STARTUP, 8'h08);
        rd(BCFG_OFS_EEADDR, 8'h50);
        for (int i = 0; i < 4; i++)
            rd(10'(BCFG_OFS_ID0 + i), ID[31 - 8 * i -: 8]);
        rd(10'h034, 8'h34 ^ 8'h3C);
        rd(10'h214, 8'h00);
        wr(10'h100, rnd8());
        rd(10'h100, 8'h00);
        rd(BCFG_OFS_LAST, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            v = rnd8();
            v[7] = i[0];
            w = rnd8();
            s = rnd8() & 8'hFB;
            wr(BCFG_OFS_EEADDR, v);
            wr(BCFG_OFS_ID3, w);
            wr(BCFG_OFS_STARTUP, s);
            rd(BCFG_OFS_EEADDR, v);
            rd(BCFG_OFS_ID3, w);
            rd(BCFG_OFS_STARTUP, s);
            idle();
            chk(ee_addr[0], v[6:0]);
            chk(two_b[0], v[7]);
            chk({loading[0], fail[0]}, 2'b00);
        end
        wr(BCFG_OFS_STARTUP, 8'h08);
        boot(1'b1, 4'h1, 9'h1FF, 1'b0);
        chk({scnt[0], fail[0]}, {4'h2, 1'b0});
        boot(1'b0, 4'h2, 9'h1FF, 1'b0);
        chk({scnt[0], fail[0]}, {4'h2, 1'b1});
        boot(1'b1, 4'h0, 9'h040, 1'b0);
        chk(fail[0], 1);
        rd(10'h034, 8'h34 ^ 8'h3C);
        rd(10'h214, 8'h01);
        boot(1'b0, 4'h0, 9'h1FF, 1'b1);
        chk(fail[0], 1);
        repeat (6) idle();
        chk(expq.size(), 0);
        results();
    end
endmodule : bcfg_top_tb
`default_nettype wire
